// ==== hw/irqg_core.sv ====
// Implementation choice: the strobed register port.
module irqg_core
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rstn,
   // register port
   input  wire irqg_pkg::irqg_bus_t bus,
   output logic [7:0]              rdData,
   // pins and slow oscillator output, asynchronous
   input  wire logic [7:0]         portIn,
   input  wire logic               slowOscIn,
   // timer side, same clock
   input  wire logic               timer0Overflow,
   input  wire logic               timer1Overflow,
   output logic                    timer0CountPulse,
   // processor core vectoring
   input  wire logic               vectorCallDone,
   output logic                    irqRequest,
   output logic [15:0]             vectorAddr,
   // power control
   input  wire logic               powerDown,
   output irqg_pkg::irqg_osc_t     osc,
   // summary interrupt
   output logic                    irqOut
);

   irqg_pkg::irqg_state_t st_ff;
   irqg_pkg::irqg_state_t nxt_st;

   logic       slowRise;
   logic       tickWrap;
   logic       wakeNow;
   logic       wakeRise;
   logic       secRise;
   logic       wrTc;
   logic       wrMisc;
   logic       rdStatus;
   logic [3:0] pending;
   logic [3:0] events;

   // first source in polling order wins
   function automatic logic [1:0] pickWinner(input logic [3:0] req);
      logic [1:0] idx;
      idx = irqg_pkg::SRC_TIMER1;
      if (req[2])
         idx = irqg_pkg::SRC_EXT1;
      if (req[1])
         idx = irqg_pkg::SRC_TIMER0;
      if (req[0])
         idx = irqg_pkg::SRC_EXT0;
      return idx;
   endfunction : pickWinner

   // fixed vector per source
   function automatic logic [15:0] vecOf(input logic [1:0] idx);
      logic [15:0] v;
      unique case (idx)
         irqg_pkg::SRC_EXT0:   v = irqg_pkg::VEC_EXT0;
         irqg_pkg::SRC_TIMER0: v = irqg_pkg::VEC_TIMER0;
         irqg_pkg::SRC_EXT1:   v = irqg_pkg::VEC_EXT1;
         irqg_pkg::SRC_TIMER1: v = irqg_pkg::VEC_TIMER1;
      endcase
      return v;
   endfunction : vecOf

   // decode of what the current cycle sees
   assign slowRise = st_ff.slowSync2 & ~st_ff.slowPrev;
   assign tickWrap = slowRise && (st_ff.tickCnt == irqg_pkg::TICK_CNT_MAX);
   assign wakeNow  = (|(~st_ff.portSync2[3:0]))
                   | (|(st_ff.portSync2[7:4] ~^ st_ff.matchLevels));
   assign wakeRise = wakeNow & ~st_ff.wakePrev;
   assign secRise  = st_ff.secFlag & ~st_ff.secPrev;
   assign wrTc     = bus.wrEn && (bus.addr == irqg_pkg::REG_TIMER_CTRL);
   assign wrMisc   = bus.wrEn && (bus.addr == irqg_pkg::REG_MISC_CTRL);
   assign rdStatus = bus.rdEn && (bus.addr == irqg_pkg::REG_IRQ_STATUS);
   // four sources only, each gated by its enable and the global enable
   assign pending  = {st_ff.tf1, st_ff.ie1, st_ff.tf0, st_ff.ie0}
                   & st_ff.enable[3:0]
                   & {4{st_ff.enable[irqg_pkg::EN_GLOBAL]}};
   assign events   = {timer1Overflow, timer0Overflow, tickWrap, wakeRise};

   // next-state logic
   always_comb
   begin
      logic ack0;
      logic ack1;
      logic ack2;
      logic ack3;
      nxt_st = st_ff;
      ack0 = vectorCallDone && st_ff.irqReq && (st_ff.winIdx == irqg_pkg::SRC_EXT0);
      ack1 = vectorCallDone && st_ff.irqReq && (st_ff.winIdx == irqg_pkg::SRC_TIMER0);
      ack2 = vectorCallDone && st_ff.irqReq && (st_ff.winIdx == irqg_pkg::SRC_EXT1);
      ack3 = vectorCallDone && st_ff.irqReq && (st_ff.winIdx == irqg_pkg::SRC_TIMER1);

      // two-flop synchronisers for pins and the slow clock
      nxt_st.portSync1 = portIn;
      nxt_st.portSync2 = st_ff.portSync1;
      nxt_st.slowSync1 = slowOscIn;
      nxt_st.slowSync2 = st_ff.slowSync1;
      nxt_st.slowPrev  = st_ff.slowSync2;
      nxt_st.slowPulse = slowRise;
      nxt_st.wakePrev  = wakeNow;
      nxt_st.secPrev   = st_ff.secFlag;

      // free-running tick counter wraps to zero
      if (slowRise)
         nxt_st.tickCnt = st_ff.tickCnt + 15'h0001;

      // overflow latch drops once the flag has taken it
      nxt_st.ovfLatch = (st_ff.ovfLatch & ~st_ff.secFlag) | tickWrap;

      // tick flag: software may set or clear, the latch always sets
      if (wrMisc)
         nxt_st.secFlag = bus.wrData[irqg_pkg::MC_SEC_FLAG];
      if (st_ff.ovfLatch)
         nxt_st.secFlag = 1'b1;

      // software writes of the request flags, hardware sets override below
      if (wrTc)
      begin
         nxt_st.tf1 = bus.wrData[irqg_pkg::TC_TF1];
         nxt_st.tf0 = bus.wrData[irqg_pkg::TC_TF0];
         nxt_st.ie1 = bus.wrData[irqg_pkg::TC_IE1];
         nxt_st.ie0 = bus.wrData[irqg_pkg::TC_IE0];
         nxt_st.it1 = bus.wrData[irqg_pkg::TC_IT1];
         nxt_st.it0 = bus.wrData[irqg_pkg::TC_IT0];
      end

      // ext0 request latch: level mode follows the source
      if (!st_ff.it0)
         nxt_st.ie0 = wakeNow;
      else if (wakeRise)
         nxt_st.ie0 = 1'b1;
      else if (ack0)
         nxt_st.ie0 = 1'b0;

      // tick request latch, edge mode is the safe choice
      if (!st_ff.it1)
         nxt_st.ie1 = st_ff.secFlag;
      else if (secRise)
         nxt_st.ie1 = 1'b1;
      else if (ack2)
         nxt_st.ie1 = 1'b0;

      // timer flags cleared by their own vector call
      if (timer0Overflow)
         nxt_st.tf0 = 1'b1;
      else if (ack1)
         nxt_st.tf0 = 1'b0;
      if (timer1Overflow)
         nxt_st.tf1 = 1'b1;
      else if (ack3)
         nxt_st.tf1 = 1'b0;

      // plain control registers
      if (bus.wrEn && (bus.addr == irqg_pkg::REG_SOURCE_EN))
         nxt_st.enable = bus.wrData & irqg_pkg::EN_WRITABLE;
      if (wrMisc)
      begin
         nxt_st.matchLevels = bus.wrData[3:0];
         nxt_st.keepSlow    = bus.wrData[irqg_pkg::MC_KEEP_SLOW];
      end
      if (bus.wrEn && (bus.addr == irqg_pkg::REG_OSC_TRIM))
         nxt_st.oscTrim = bus.wrData[4:0];
      if (bus.wrEn && (bus.addr == irqg_pkg::REG_IRQ_MASK))
         nxt_st.mask = bus.wrData[3:0];

      // sticky status: read clears, a new event in that cycle survives
      nxt_st.status = (rdStatus ? 4'h0 : st_ff.status) | events;

      // poll and present the winner to the core
      nxt_st.irqReq     = |pending;
      nxt_st.winIdx     = pickWinner(pending);
      nxt_st.vectorAddr = vecOf(pickWinner(pending));

      // read data only in the cycle after the strobe
      nxt_st.rdData = 8'h00;
      if (bus.rdEn)
      begin
         unique case (bus.addr)
            irqg_pkg::REG_TIMER_CTRL:
               nxt_st.rdData = {st_ff.tf1, 1'b0, st_ff.tf0, 1'b0,
                                st_ff.ie1, st_ff.it1, st_ff.ie0, st_ff.it0};
            irqg_pkg::REG_MISC_CTRL:
               nxt_st.rdData = {2'h0, st_ff.keepSlow, st_ff.secFlag, st_ff.matchLevels};
            irqg_pkg::REG_OSC_TRIM:   nxt_st.rdData = {3'h0, st_ff.oscTrim};
            irqg_pkg::REG_IRQ_STATUS: nxt_st.rdData = {4'h0, st_ff.status};
            irqg_pkg::REG_IRQ_MASK:   nxt_st.rdData = {4'h0, st_ff.mask};
            irqg_pkg::REG_VECTOR_LO:  nxt_st.rdData = st_ff.vectorAddr[7:0];
            irqg_pkg::REG_SOURCE_EN:  nxt_st.rdData = st_ff.enable;
            default:                  nxt_st.rdData = 8'h00;
         endcase
      end
   end

   // state register, everything clears on reset except the pin synchronisers, which load all ones
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff          <= '0;
         st_ff.enable   <= irqg_pkg::RST_SOURCE_EN;
         st_ff.oscTrim  <= irqg_pkg::RST_OSC_TRIM;
         st_ff.tickCnt  <= irqg_pkg::RST_TICK_CNT;
         // pins idle high; a zero here would fake a wake edge right after reset
         st_ff.portSync1 <= irqg_pkg::RST_PORT_SYNC;
         st_ff.portSync2 <= irqg_pkg::RST_PORT_SYNC;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign rdData           = st_ff.rdData;
   assign irqRequest       = st_ff.irqReq;
   assign vectorAddr       = st_ff.vectorAddr;
   assign timer0CountPulse = st_ff.slowPulse;
   assign irqOut           = |(st_ff.status & st_ff.mask);
   // oscillator gating in power-down
   assign osc.cpuOscEnable  = ~powerDown;
   assign osc.slowOscEnable = ~powerDown | st_ff.keepSlow;
   assign osc.oscTrim       = st_ff.oscTrim;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_wrap;
      tickWrap && !wrMisc;
   endsequence
   sequence s_flag_chain;
      ##1 st_ff.ovfLatch ##1 st_ff.secFlag;
   endsequence

   a_tick_chain: assert property (s_wrap |-> s_flag_chain)
      else $error("tick overflow did not reach the tick flag");
   a_tick_step: assert property (slowRise
                                 |=> st_ff.tickCnt == $past(st_ff.tickCnt) + 15'h0001)
      else $error("tick counter did not advance");
   a_tick_hold: assert property (!slowRise |=> $stable(st_ff.tickCnt))
      else $error("tick counter moved without a slow edge");
   a_flag_sticky: assert property (st_ff.secFlag && !wrMisc |=> st_ff.secFlag)
      else $error("tick flag dropped without software");
   a_wake_level: assert property (!st_ff.it0 && !wrTc |=> st_ff.ie0 == $past(wakeNow))
      else $error("level mode request does not follow source");
   a_edge_clear: assert property (st_ff.it0 && st_ff.irqReq && vectorCallDone
                                  && st_ff.winIdx == irqg_pkg::SRC_EXT0 && !wakeRise
                                  && !wrTc |=> !st_ff.ie0)
      else $error("edge request not cleared by vector call");
   a_timer_set: assert property (timer0Overflow || timer1Overflow
                                 |=> (st_ff.tf0 || !$past(timer0Overflow))
                                 && (st_ff.tf1 || !$past(timer1Overflow)))
      else $error("timer flag not set by overflow");
   a_global_gate: assert property (st_ff.irqReq
                                   |-> $past(st_ff.enable[irqg_pkg::EN_GLOBAL]))
      else $error("request raised with global enable low");
   a_poll_order: assert property (st_ff.irqReq && st_ff.winIdx == irqg_pkg::SRC_EXT1
                                  |-> $past(pending[1:0]) == 2'h0)
      else $error("lower source won over a higher one");
   a_vector_map: assert property (st_ff.irqReq && st_ff.winIdx == irqg_pkg::SRC_TIMER0
                                  |-> vectorAddr == irqg_pkg::VEC_TIMER0)
      else $error("timer0 vector address wrong");
   a_sw_set: assert property (wrTc && bus.wrData[irqg_pkg::TC_TF1] && !vectorCallDone
                              |=> st_ff.tf1)
      else $error("software set of timer1 flag lost");
   a_osc_gate: assert property (powerDown |-> !osc.cpuOscEnable
                                && (osc.slowOscEnable == st_ff.keepSlow))
      else $error("oscillator enables wrong in power-down");
   a_count_pulse: assert property (slowRise |=> timer0CountPulse ##1 !timer0CountPulse)
      else $error("timer0 count pulse wrong");
   // read data fall back to zero so a stale byte is never taken twice
   a_read_once: assert property (!bus.rdEn |=> rdData == 8'h00)
      else $error("read data stood outside its cycle");
   a_status_clear: assert property (rdStatus && events == 4'h0 |=> st_ff.status == 4'h0)
      else $error("status not cleared by its read");
   a_wake_latch: assert property (st_ff.it0 && wakeRise |=> st_ff.ie0)
      else $error("edge request not latched");
   a_tick_level: assert property (!st_ff.it1 |=> st_ff.ie1 == $past(st_ff.secFlag))
      else $error("level tick request does not follow the flag");

endmodule : irqg_core

// ==== pkg/irqg_pkg.sv ====
// Notes on behaviour
// - 15-bit tick counter advances on each slow-clock cycle, overflows on wrap.
// - overflow caught in a latch that sets the tick flag, then clears itself.
// - tick flag raises the tick interrupt and stays until software clears it.
// - wake request when a low port line is 0 or upper line equals its match level.
// - ext0 level mode: request follows the source; software must remove it first.
// - ext0 edge mode: request latch cleared when the vector call executes.
// - timer flags set on overflow, cleared when their vector call executes.
// - software writes to interrupt flags act like hardware sets and clears, except ie0 and ie1 in level mode, which follow their source.
// - exactly four sources: port wake, tick, timer 0 and timer 1.
// - global enable low blocks all; high gates each source by its own enable; irqOut from status and mask is not gated by it.
// - enable bits: 3 timer1, 2 ext1, 1 timer0, 0 ext0; bits 6 to 4 reserved.
// - slow oscillator output is the counting input of timer 0.
// - in power-down the slow oscillator runs only when keep-running is set.
// - cpu oscillator stops in power-down.
// - cpu oscillator trim code 0 to 31 selects frequency in even steps.
// - vectors: ext0 0003h, timer0 000bh, ext1 0013h, timer1 001bh.
// - simultaneous requests polled: ext0, timer0, ext1, timer1.
package irqg_pkg;
   // register byte addresses
   localparam logic [7:0] REG_TIMER_CTRL  = 8'h88;
   localparam logic [7:0] REG_MISC_CTRL   = 8'h90;
   localparam logic [7:0] REG_OSC_TRIM    = 8'h94;
   localparam logic [7:0] REG_IRQ_STATUS  = 8'h98;
   localparam logic [7:0] REG_IRQ_MASK    = 8'h9c;
   localparam logic [7:0] REG_VECTOR_LO   = 8'ha0;
   localparam logic [7:0] REG_SOURCE_EN   = 8'ha8;
   // timer_control_reg fields
   localparam int TC_TF1 = 7;
   localparam int TC_TF0 = 5;
   localparam int TC_IE1 = 3;
   localparam int TC_IT1 = 2;
   localparam int TC_IE0 = 1;
   localparam int TC_IT0 = 0;
   // misc_control_reg fields
   localparam int MC_KEEP_SLOW = 5;
   localparam int MC_SEC_FLAG  = 4;
   // source_enable_mask fields
   localparam int EN_GLOBAL = 7;
   localparam logic [7:0] EN_WRITABLE = 8'h8f;
   // reset values and tick counter maximum
   localparam logic [7:0]  RST_SOURCE_EN = 8'h00;
   localparam logic [4:0]  RST_OSC_TRIM  = 5'h00;
   localparam logic [7:0]  RST_PORT_SYNC = 8'hff;
   localparam logic [14:0] RST_TICK_CNT  = 15'h0000;
   localparam logic [14:0] TICK_CNT_MAX  = 15'h7fff;
   // source indices in polling order
   localparam logic [1:0] SRC_EXT0   = 2'h0;
   localparam logic [1:0] SRC_TIMER0 = 2'h1;
   localparam logic [1:0] SRC_EXT1   = 2'h2;
   localparam logic [1:0] SRC_TIMER1 = 2'h3;
   // vector addresses
   localparam logic [15:0] VEC_EXT0   = 16'h0003;
   localparam logic [15:0] VEC_TIMER0 = 16'h000b;
   localparam logic [15:0] VEC_EXT1   = 16'h0013;
   localparam logic [15:0] VEC_TIMER1 = 16'h001b;

   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic       wrEn;
      logic       rdEn;
   } irqg_bus_t;

   // oscillator controls
   typedef struct packed {
      logic       cpuOscEnable;
      logic       slowOscEnable;
      logic [4:0] oscTrim;
   } irqg_osc_t;

   // all state of the block
   typedef struct packed {
      logic [7:0]  portSync1;
      logic [7:0]  portSync2;
      logic        slowSync1;
      logic        slowSync2;
      logic        slowPrev;
      logic        slowPulse;
      logic [14:0] tickCnt;
      logic        ovfLatch;
      logic        secFlag;
      logic        wakePrev;
      logic        secPrev;
      logic        ie0;
      logic        ie1;
      logic        tf0;
      logic        tf1;
      logic        it0;
      logic        it1;
      logic [7:0]  enable;
      logic [3:0]  matchLevels;
      logic        keepSlow;
      logic [4:0]  oscTrim;
      logic [3:0]  status;
      logic [3:0]  mask;
      logic [7:0]  rdData;
      logic        irqReq;
      logic [1:0]  winIdx;
      logic [15:0] vectorAddr;
   } irqg_state_t;
endpackage : irqg_pkg

// ==== verification/irqg_core_model.sv ====
module irqg_core_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // vectoring side of the block
   input  wire logic        irqRequest,
   input  wire logic [15:0] vectorAddr,
   output logic             vectorCallDone = 1'b0,
   // bench controls
   input  wire logic        ackOn,
   input  wire logic [3:0]  ackDelay,
   // slow oscillator pin
   input  wire logic        slowRun,
   output logic             slowOscIn = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] vecLog[$];

   // core takes a pending request after a chosen delay and logs the vector that
   // stands at the edge where the call is taken; afterwards it waits until the
   // cleared latch reaches irqRequest, so one event is not taken twice
   always
   begin
      @(posedge clk);
      if (rstn && ackOn && irqRequest === 1'b1)
      begin
         repeat (ackDelay) @(posedge clk);
         vectorCallDone <= 1'b1;
         @(posedge clk);
         if (irqRequest === 1'b1)
            vecLog.push_back(vectorAddr);
         vectorCallDone <= 1'b0;
         repeat (3) @(posedge clk);
      end
   end

   // slow oscillator, 4 clk high and 4 low; frozen while its enable is low
   always
   begin
      repeat (4) @(posedge clk);
      if (slowRun === 1'b1)
         slowOscIn <= ~slowOscIn;
   end
endmodule : irqg_core_model

// ==== verification/tb.sv ====
`define IRQG_CHK(a, e) \
   begin \
      nCompared++; \
      if ((a) !== (e)) \
      begin \
         mismatches++; \
         $display("unexpected at %0t: got %h expected %h", $time, a, e); \
      end \
   end

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk = 1'b0;
   logic                rstn;
   irqg_pkg::irqg_bus_t bus;
   logic [7:0]          rdData;
   logic [7:0]          portIn;
   logic                slowOscIn;
   logic                timer0Overflow;
   logic                timer1Overflow;
   logic                timer0CountPulse;
   logic                vectorCallDone;
   logic                irqRequest;
   logic [15:0]         vectorAddr;
   logic                powerDown;
   irqg_pkg::irqg_osc_t osc;
   logic                irqOut;
   logic                ackOn;
   logic [3:0]          ackDelay;
   logic [7:0]          rdVal;
   logic [3:0]          matchLvl;
   logic [7:0]          p;
   int                  seed = 26;
   int                  mismatches = 0;
   int                  nCompared = 0;
   int                  cycles = 0;
   int                  pulseCnt = 0;
   int                  pulseTotal = 0;

   irqg_core irqg_core_i (.clk(clk), .rstn(rstn), .bus(bus), .rdData(rdData), .portIn(portIn),
      .slowOscIn(slowOscIn), .timer0Overflow(timer0Overflow), .timer1Overflow(timer1Overflow),
      .timer0CountPulse(timer0CountPulse), .vectorCallDone(vectorCallDone),
      .irqRequest(irqRequest), .vectorAddr(vectorAddr), .powerDown(powerDown), .osc(osc),
      .irqOut(irqOut));

   irqg_core_model irqg_core_model_i (.clk(clk), .rstn(rstn), .irqRequest(irqRequest),
      .vectorAddr(vectorAddr), .vectorCallDone(vectorCallDone), .ackOn(ackOn),
      .ackDelay(ackDelay), .slowRun(osc.slowOscEnable), .slowOscIn(slowOscIn));

   // 50 MHz clock
   initial
   begin
      forever #10 clk = ~clk;
   end

   // cycle ceiling cuts a hang short; timer 0 counting pulses are tallied
   always @(posedge clk)
   begin
      cycles++;
      if (timer0CountPulse === 1'b1)
      begin
         pulseCnt++;
         pulseTotal++;
      end
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end

   // wake expectation: any low line of the lower four, or an upper line at its level
   function automatic logic wake_exp(input logic [7:0] pv, input logic [3:0] ml);
      return (~&pv[3:0]) | (|(~(pv[7:4] ^ ml)));
   endfunction : wake_exp

   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      @(posedge clk);
      bus <= '{addr: a, wrData: dv, wrEn: 1'b1, rdEn: 1'b0};
      @(posedge clk);
      bus.wrEn <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      bus <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
      @(posedge clk);
      bus.rdEn <= 1'b0;
      #1 rdVal = rdData;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic finish_test();
      $display("mismatches %0d compared %0d", mismatches, nCompared);
      if (mismatches == 0 && nCompared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   initial
   begin
      bus = '0;
      portIn = 8'hff;
      timer0Overflow = 1'b0;
      timer1Overflow = 1'b0;
      powerDown = 1'b0;
      ackOn = 1'b0;
      ackDelay = 4'h0;
      rstn = 1'b0;
      matchLvl = 4'h0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      // reset value, unmapped place and reserved bits
      rd(irqg_pkg::REG_SOURCE_EN);
      `IRQG_CHK(rdVal, 8'h00)
      rd(8'h00);
      `IRQG_CHK(rdVal, 8'h00)
      wr(irqg_pkg::REG_SOURCE_EN, 8'hff);
      rd(irqg_pkg::REG_SOURCE_EN);
      `IRQG_CHK(rdVal, 8'h8f)
      // both timers overflow while the global enable is off
      wr(irqg_pkg::REG_SOURCE_EN, 8'h0a);
      @(posedge clk);
      timer0Overflow <= 1'b1;
      timer1Overflow <= 1'b1;
      @(posedge clk);
      timer0Overflow <= 1'b0;
      timer1Overflow <= 1'b0;
      settle(4);
      `IRQG_CHK(irqRequest, 1'b0)
      rd(irqg_pkg::REG_TIMER_CTRL);
      `IRQG_CHK(rdVal & 8'ha0, 8'ha0)
      // global on: both pending at once, polled in fixed order
      ackOn <= 1'b1;
      ackDelay <= 4'($unsigned($random(seed)) % 4);
      wr(irqg_pkg::REG_SOURCE_EN, 8'h8a);
      for (int i = 0; i < 60 && irqg_core_model_i.vecLog.size() < 2; i++)
         @(posedge clk);
      `IRQG_CHK(irqg_core_model_i.vecLog[0], irqg_pkg::VEC_TIMER0)
      `IRQG_CHK(irqg_core_model_i.vecLog[1], irqg_pkg::VEC_TIMER1)
      rd(irqg_pkg::REG_TIMER_CTRL);
      `IRQG_CHK(rdVal & 8'ha0, 8'h00)
      // software raises and cancels a timer request
      ackOn <= 1'b0;
      // both timer flags raised by software; timer 0 must win the poll
      wr(irqg_pkg::REG_TIMER_CTRL, 8'ha0);
      settle(3);
      `IRQG_CHK({irqRequest, vectorAddr}, {1'b1, irqg_pkg::VEC_TIMER0})
      wr(irqg_pkg::REG_TIMER_CTRL, 8'h00);
      settle(3);
      `IRQG_CHK(irqRequest, 1'b0)
      // random port patterns in level mode, corners first
      matchLvl = 4'($random(seed));
      wr(irqg_pkg::REG_MISC_CTRL, {4'h0, matchLvl});
      for (int i = 0; i < 16; i++)
      begin
         p = (i == 0) ? {~matchLvl, 4'hf} : (i == 1) ? {~matchLvl[3:1], matchLvl[0], 4'hf} :
             (i == 2) ? {~matchLvl, 4'h7} : 8'($random(seed));
         portIn <= p;
         settle(5);
         rd(irqg_pkg::REG_TIMER_CTRL);
         `IRQG_CHK(rdVal[1], wake_exp(p, matchLvl))
      end
      // level request survives the call until the source goes away
      portIn <= {~matchLvl, 4'hf};
      wr(irqg_pkg::REG_SOURCE_EN, 8'h81);
      portIn <= 8'hf7;
      settle(4);
      `IRQG_CHK({irqRequest, vectorAddr}, {1'b1, irqg_pkg::VEC_EXT0})
      ackOn <= 1'b1;
      settle(10);
      `IRQG_CHK(irqRequest, 1'b1)
      portIn <= {~matchLvl, 4'hf};
      settle(6);
      `IRQG_CHK(irqRequest, 1'b0)
      // edge mode: a short pulse is held until the call
      ackOn <= 1'b0;
      wr(irqg_pkg::REG_TIMER_CTRL, 8'h01);
      portIn <= 8'hfe;
      settle(4);
      portIn <= {~matchLvl, 4'hf};
      settle(6);
      `IRQG_CHK(irqRequest, 1'b1)
      ackOn <= 1'b1;
      settle(12);
      `IRQG_CHK({irqRequest, irqg_core_model_i.vecLog[$]}, {1'b0, irqg_pkg::VEC_EXT0})
      // tick flag set by software in edge mode; it outlives the call
      ackOn <= 1'b0;
      wr(irqg_pkg::REG_TIMER_CTRL, 8'h04); // edge mode kept for the tick
      wr(irqg_pkg::REG_SOURCE_EN, 8'h84);
      wr(irqg_pkg::REG_MISC_CTRL, {4'h1, matchLvl});
      settle(4);
      `IRQG_CHK({irqRequest, vectorAddr}, {1'b1, irqg_pkg::VEC_EXT1})
      rd(irqg_pkg::REG_VECTOR_LO);
      `IRQG_CHK(rdVal, irqg_pkg::VEC_EXT1[7:0])
      ackOn <= 1'b1;
      settle(10);
      rd(irqg_pkg::REG_MISC_CTRL);
      `IRQG_CHK({irqRequest, rdVal[4]}, 2'b01)
      wr(irqg_pkg::REG_MISC_CTRL, {4'h0, matchLvl});
      rd(irqg_pkg::REG_MISC_CTRL);
      `IRQG_CHK(rdVal[4], 1'b0)
      // status, mask and interrupt output
      ackOn <= 1'b0;
      rd(irqg_pkg::REG_IRQ_STATUS);
      wr(irqg_pkg::REG_IRQ_MASK, 8'h00);
      timer1Overflow <= 1'b1;
      @(posedge clk);
      timer1Overflow <= 1'b0;
      settle(3);
      `IRQG_CHK(irqOut, 1'b0)
      wr(irqg_pkg::REG_IRQ_MASK, 8'h08);
      settle(2);
      `IRQG_CHK(irqOut, 1'b1)
      rd(irqg_pkg::REG_IRQ_STATUS);
      `IRQG_CHK(rdVal, 8'h08)
      settle(2);
      `IRQG_CHK(irqOut, 1'b0)
      // trim code and power-down with and without the keep bit
      p = 8'($unsigned($random(seed)) % 32);
      wr(irqg_pkg::REG_OSC_TRIM, p);
      settle(1);
      `IRQG_CHK(osc.oscTrim, p[4:0])
      for (int k = 0; k < 2; k++)
      begin
         wr(irqg_pkg::REG_MISC_CTRL, {2'b00, 1'(k), 1'b0, matchLvl});
         powerDown <= 1'b1;
         settle(6);
         `IRQG_CHK({osc.cpuOscEnable, osc.slowOscEnable}, {1'b0, 1'(k)})
         pulseCnt = 0;
         settle(40);
         `IRQG_CHK(k ? (pulseCnt >= 4 && pulseCnt <= 6) : (pulseCnt == 0), 1'b1)
         // slow clock frozen here, so the tick count must equal every edge seen
         if (k == 0)
            `IRQG_CHK(irqg_core_i.st_ff.tickCnt, 15'(pulseTotal))
         powerDown <= 1'b0;
      end
      finish_test();
   end
endmodule : tb
